// File: sppc_pkg.sv
/*
 sleep power plane control package: state encoding, event carrier, defaults.
 assumes a single always-on clock and asynchronous active-low reset.
*/
// Summary of operation
// - power return after G3 from S4 resumes to S0 or stays in S4.
// - power-button override into S5 continues to deep sleep when enabled and allowed.
// - selected wake events survive main power loss and act once power returns.
// - S3 indicator active in S3; memory stays powered, rest may go off.
// - S4 indicator active in S4; memory may be powered down too.
// - S5 indicator active in soft-off; everything but restart logic may go off.
// - management sleep output asserted while management platform is fully off.
// - LAN power-down asserted in sleep or management-off only without any wake-on-LAN.
// - suspend-well sleep asserted only when primary and suspend rails may go off.
// - deep sleep resume returns to the S3, S4 or S5 it came from.
package sppc_pkg;

    typedef enum logic [2:0] {
        SPPC_S0,
        SPPC_S3,
        SPPC_S4,
        SPPC_S5,
        SPPC_DEEP,
        SPPC_G3
    } sppc_state_t;

    // one-cycle request pulses from the surrounding power manager
    typedef struct packed {
        logic sleep_s3;
        logic sleep_s4;
        logic sleep_s5;
        logic pwrbtn_override;
        logic wake;
        logic deep_ok;
        logic power_fail;
        logic power_return;
    } sppc_evt_t;

    // configuration levels
    typedef struct packed {
        logic after_g3_off;
        logic deep_en;
        logic host_wol;
        logic mgmt_wol;
        logic sus_off_allowed;
        logic wake_keep;
    } sppc_cfg_t;

    // indicator bundle, all active low
    typedef struct packed {
        logic sleep_s3_n;
        logic sleep_s4_n;
        logic sleep_s5_n;
        logic mgmt_sleep_n;
        logic lan_power_down_n;
        logic suspend_well_sleep_n;
    } sppc_pins_t;

    localparam sppc_pins_t SPPC_PINS_RESET = 6'h3F;
    localparam sppc_state_t SPPC_RESET_STATE = SPPC_S0;
    localparam logic        SPPC_WAKE_RESET  = 1'h0;

endpackage : sppc_pkg

// File: sppc_sleep_power.sv
/*
 sleep state tracker driving active-low power plane indicators.
 holds the sleep state, its origin for deep sleep and mechanical off, and one
 retained wake flag; indicators are registered from the next state.
 assumes events are synchronous single-cycle pulses; no software registers.
 a level held on an event input acts again on every edge.
*/
`timescale 1ns/1ps
module sppc_sleep_power
    import sppc_pkg::*;
(
    // clock and reset
    input  wire logic        I_CLOCK,
    input  wire logic        I_RESETN,
    // events and configuration
    input  wire sppc_evt_t   I_EVT,
    input  wire sppc_cfg_t   I_CFG,
    input  wire logic        I_MGMT_OFF,
    input  wire logic        I_PRESERVED_WAKE,
    // power plane indicators
    output logic             O_SLEEP_S3_N,
    output logic             O_SLEEP_S4_N,
    output logic             O_SLEEP_S5_N,
    output logic             O_MGMT_SLEEP_N,
    output logic             O_LAN_POWER_DOWN_N,
    output logic             O_SUSPEND_WELL_SLEEP_N,
    // state and retained wake
    output sppc_state_t      O_STATE,
    output logic             O_WAKE_PENDING
);

    // state and retained context
    sppc_state_t state_q;
    sppc_state_t state_d;
    sppc_state_t prior_q;          // sleep state before deep sleep or G3
    sppc_state_t prior_d;
    sppc_pins_t  pins_q;
    sppc_pins_t  pins_d;
    logic        wake_q;
    logic        wake_d;

    // event qualification
    logic        fail_now;
    logic        wake_now;
    logic        deep_go;
    logic        ovr_go;
    logic        sleeping;

    // resume targets
    logic        from_s4;
    sppc_state_t off_state;
    sppc_state_t g3_resume;
    sppc_state_t s0_target;

    // indicator requests, active high before inversion
    logic        deep_from_s3;
    logic        deep_from_s5;
    logic        ask_s3;
    logic        ask_s4;
    logic        ask_s5;
    logic        ask_mgmt;
    logic        any_wol;
    logic        lan_idle;
    logic        ask_lan;
    logic        rails_low;
    logic        ask_sus;

    // wake retention controls
    logic        capture_wake;
    logic        consume_wake;

    // power loss beats every other request outside G3
    assign fail_now  = I_EVT.power_fail && (state_q != SPPC_G3);
    // retained wake counts as a wake once power is back
    assign wake_now  = I_EVT.wake | wake_q;
    assign deep_go   = I_CFG.deep_en & I_EVT.deep_ok;
    assign ovr_go    = I_EVT.pwrbtn_override;
    assign sleeping  = (state_d != SPPC_S0);

    // priority in S0: override, then S3, S4, S5 requests
    assign s0_target = ovr_go         ? SPPC_S5 :
                       I_EVT.sleep_s3 ? SPPC_S3 :
                       I_EVT.sleep_s4 ? SPPC_S4 :
                       I_EVT.sleep_s5 ? SPPC_S5 : SPPC_S0;

    // without the off option a return from mechanical off always reboots
    assign from_s4   = (prior_q == SPPC_S4);
    assign off_state = from_s4 ? SPPC_S4 : SPPC_S5;
    assign g3_resume = I_CFG.after_g3_off ? off_state : SPPC_S0;

    always_comb begin
        state_d = state_q;
        prior_d = prior_q;
        if (fail_now) begin
            state_d = SPPC_G3;
            prior_d = state_q;
        end else begin
            case (state_q)
                SPPC_S0: begin
                    state_d = s0_target;
                end
                SPPC_S3, SPPC_S4: begin
                    if (ovr_go) begin
                        state_d = SPPC_S5;
                    end else if (wake_now) begin
                        state_d = SPPC_S0;
                    end else if (deep_go) begin
                        state_d = SPPC_DEEP;
                        prior_d = state_q;
                    end
                end
                SPPC_S5: begin
                    if (wake_now) begin
                        state_d = SPPC_S0;
                    end else if (deep_go) begin
                        state_d = SPPC_DEEP;
                        prior_d = SPPC_S5;
                    end
                end
                SPPC_DEEP: begin
                    if (wake_now) begin
                        state_d = SPPC_S0;
                    end else if (I_EVT.power_return) begin
                        state_d = prior_q;
                    end
                end
                SPPC_G3: begin
                    if (I_EVT.power_return) begin
                        state_d = g3_resume;
                    end
                end
                default: begin
                    state_d = SPPC_RESET_STATE;
                end
            endcase
        end
    end

    // capture only while the rails are down, consume once running again;
    // the two cannot meet in one cycle, but capture is checked first
    assign capture_wake = (state_q == SPPC_G3) && !I_EVT.power_return &&
                          I_CFG.wake_keep && I_PRESERVED_WAKE;
    assign consume_wake = (state_q != SPPC_G3) && wake_q;

    always_comb begin
        wake_d = wake_q;
        if (capture_wake) begin
            wake_d = 1'h1;
        end else if (consume_wake) begin
            wake_d = 1'h0;
        end
    end

    // indicators: deeper sleep implies shallower ones asserted
    assign deep_from_s3 = (state_d == SPPC_DEEP) && (prior_d == SPPC_S3);
    assign deep_from_s5 = (state_d == SPPC_DEEP) && (prior_d == SPPC_S5);
    assign ask_s3       = state_d inside {SPPC_S3, SPPC_S4, SPPC_S5,
                                          SPPC_DEEP, SPPC_G3};
    // deep sleep out of S3 keeps memory powered for the saved context
    assign ask_s4       = (state_d inside {SPPC_S4, SPPC_S5, SPPC_DEEP, SPPC_G3}) &&
                          !deep_from_s3;
    assign ask_s5       = (state_d inside {SPPC_S5, SPPC_G3}) || deep_from_s5;
    // management request follows its level in every state; lan request only in sleep or management-off
    assign ask_mgmt     = I_MGMT_OFF;
    assign any_wol      = I_CFG.host_wol | I_CFG.mgmt_wol;
    assign lan_idle     = sleeping | I_MGMT_OFF;
    assign ask_lan      = lan_idle & !any_wol;
    // hub itself hangs off this rail, so only when the board allows it
    assign rails_low    = (state_d == SPPC_DEEP) || (state_d == SPPC_G3);
    assign ask_sus      = I_CFG.sus_off_allowed && rails_low;

    always_comb begin
        pins_d                      = SPPC_PINS_RESET;
        pins_d.sleep_s3_n           = !ask_s3;
        pins_d.sleep_s4_n           = !ask_s4;
        pins_d.sleep_s5_n           = !ask_s5;
        pins_d.mgmt_sleep_n         = !ask_mgmt;
        pins_d.lan_power_down_n     = !ask_lan;
        pins_d.suspend_well_sleep_n = !ask_sus;
    end

    // state and its origin move together
    always_ff @(posedge I_CLOCK or negedge I_RESETN) begin
        if (!I_RESETN) begin
            state_q <= SPPC_RESET_STATE;
            prior_q <= SPPC_RESET_STATE;
        end else begin
            state_q <= state_d;
            prior_q <= prior_d;
        end
    end

    // pins taken from next state so they line up with the state output
    always_ff @(posedge I_CLOCK or negedge I_RESETN) begin
        if (!I_RESETN) begin
            pins_q <= SPPC_PINS_RESET;
        end else begin
            pins_q <= pins_d;
        end
    end

    // retained wake flag
    always_ff @(posedge I_CLOCK or negedge I_RESETN) begin
        if (!I_RESETN) begin
            wake_q <= SPPC_WAKE_RESET;
        end else begin
            wake_q <= wake_d;
        end
    end

    assign O_SLEEP_S3_N           = pins_q.sleep_s3_n;
    assign O_SLEEP_S4_N           = pins_q.sleep_s4_n;
    assign O_SLEEP_S5_N           = pins_q.sleep_s5_n;
    assign O_MGMT_SLEEP_N         = pins_q.mgmt_sleep_n;
    assign O_LAN_POWER_DOWN_N     = pins_q.lan_power_down_n;
    assign O_SUSPEND_WELL_SLEEP_N = pins_q.suspend_well_sleep_n;
    assign O_STATE                = state_q;
    assign O_WAKE_PENDING         = wake_q;

endmodule : sppc_sleep_power

// File: sppc_sleep_power_chk.sv
/* sleep indicator checker; assumes a bind onto the design top, one clock. */
`timescale 1ns/1ps
module sppc_sleep_power_chk import sppc_pkg::*; (
    // watched ports
    input wire logic        I_CLOCK,
    input wire logic        I_RESETN,
    input wire sppc_evt_t   I_EVT,
    input wire sppc_cfg_t   I_CFG,
    input wire logic        I_MGMT_OFF,
    input wire logic        I_PRESERVED_WAKE,
    input wire logic        O_SLEEP_S3_N,
    input wire logic        O_SLEEP_S4_N,
    input wire logic        O_SLEEP_S5_N,
    input wire logic        O_MGMT_SLEEP_N,
    input wire logic        O_LAN_POWER_DOWN_N,
    input wire logic        O_SUSPEND_WELL_SLEEP_N,
    input wire sppc_state_t O_STATE,
    input wire logic        O_WAKE_PENDING
);
    default clocking @(posedge I_CLOCK); endclocking
    default disable iff (!I_RESETN);
    AST_S0: assert property (O_STATE == SPPC_S0 |-> O_SLEEP_S3_N) else $error("s0");
    AST_S3: assert property (O_STATE == SPPC_S3 |-> !O_SLEEP_S3_N) else $error("s3");
    AST_S4: assert property (O_STATE == SPPC_S4 |->
        !O_SLEEP_S4_N && !O_SLEEP_S3_N) else $error("s4");
    AST_S5: assert property (O_STATE == SPPC_S5 |-> !O_SLEEP_S5_N) else $error("s5");
    AST_MG: assert property (1 |=> O_MGMT_SLEEP_N != $past(I_MGMT_OFF)) else $error("mg");
    AST_LAN: assert property (!O_LAN_POWER_DOWN_N |->
        !$past(I_CFG.host_wol) && !$past(I_CFG.mgmt_wol)) else $error("ln");
    AST_SUS: assert property (!O_SUSPEND_WELL_SLEEP_N |->
        O_STATE inside {SPPC_DEEP, SPPC_G3} && $past(I_CFG.sus_off_allowed)) else $error("su");
    AST_DP: assert property (O_STATE == SPPC_S5 && I_EVT == 8'h04 && I_CFG.deep_en
        && !O_WAKE_PENDING |=> O_STATE == SPPC_DEEP) else $error("dp");
    AST_G3: assert property (I_EVT.power_fail |=> O_STATE == SPPC_G3) else $error("g3");
endmodule : sppc_sleep_power_chk
bind sppc_sleep_power sppc_sleep_power_chk i_chk (.*);

// File: sppc_rails.sv
/* rail switch model; assumes active-low indicators, gives a rail-on level. */
`timescale 1ns/1ps
module sppc_rails (
    // indicators in, rail out
    input  wire logic [5:0] i_pins,
    output logic            o_hub_on
);
    // hub follows suspend-well sleep only: it has no main well
    assign o_hub_on = i_pins[0];
endmodule : sppc_rails

// File: tb.sv
/* sleep indicator bench; assumes an 8 ns clock and the rail model. */
`timescale 1ns/1ps
module tb import sppc_pkg::*; ;
    logic I_CLOCK = 0, I_RESETN = 0, I_MGMT_OFF = 0, I_PRESERVED_WAKE = 0;
    sppc_evt_t I_EVT = '0;
    sppc_cfg_t I_CFG = 6'h12;
    sppc_state_t O_STATE;
    logic O_SLEEP_S3_N, O_SLEEP_S4_N, O_SLEEP_S5_N, O_MGMT_SLEEP_N, O_LAN_POWER_DOWN_N;
    logic O_SUSPEND_WELL_SLEEP_N, O_WAKE_PENDING, hub_on;
    int n_fail = 0, checks = 0;
    wire [5:0] pins = {O_SLEEP_S3_N, O_SLEEP_S4_N, O_SLEEP_S5_N, O_MGMT_SLEEP_N,
        O_LAN_POWER_DOWN_N, O_SUSPEND_WELL_SLEEP_N};
    always #4 I_CLOCK = ~I_CLOCK;
    sppc_sleep_power i_sppc_sleep_power (.*);
    sppc_rails i_sppc_rails (.i_pins(pins), .o_hub_on(hub_on));
    task chk(input logic [8:0] got, exp);
        checks++;
        if (got !== exp) n_fail++;
        if (got !== exp) $display("ERROR %0t: got %h exp %h", $time, got, exp);
    endtask : chk
    // events are one-cycle pulses, so clear before judging
    task step(input logic [7:0] e, sppc_state_t s, logic [5:0] p);
        I_EVT = e;
        @(posedge I_CLOCK) #1 I_EVT = '0;
        chk({O_STATE, pins}, {s, p});
    endtask : step
    task results;
        $display("checks %0d n_fail %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : results
    task t_s3;
        step(8'h80, SPPC_S3, 6'h1D);
        step(8'h04, SPPC_DEEP, 6'h1C);
        chk({8'h0, hub_on}, 9'h000);
        step(8'h01, SPPC_S3, 6'h1D);
    endtask : t_s3
    task t_ovr;
        I_CFG = 6'h18;
        I_MGMT_OFF = 1;
        step(8'h10, SPPC_S5, 6'h03);
        step(8'h04, SPPC_DEEP, 6'h03);
        step(8'h08, SPPC_S0, 6'h3B);
    endtask : t_ovr
    task t_g3;
        I_CFG = 6'h29;
        step(8'h40, SPPC_S4, 6'h0B);
        step(8'h02, SPPC_G3, 6'h03);
        I_PRESERVED_WAKE = 1;
        step(8'h00, SPPC_G3, 6'h03);
        chk({8'h0, O_WAKE_PENDING}, 9'h001);
        step(8'h01, SPPC_S4, 6'h0B);
        step(8'h00, SPPC_S0, 6'h3B);
        chk({8'h0, O_WAKE_PENDING}, 9'h000);
    endtask : t_g3
    task t_g3_off;
        I_PRESERVED_WAKE = 0;
        step(8'h20, SPPC_S5, 6'h03);
        step(8'h02, SPPC_G3, 6'h03);
        step(8'h01, SPPC_S5, 6'h03);
        I_CFG = 6'h04;
        I_PRESERVED_WAKE = 1;
        step(8'h02, SPPC_G3, 6'h03);
        step(8'h00, SPPC_G3, 6'h03);
        chk({8'h0, O_WAKE_PENDING}, 9'h000);
        step(8'h01, SPPC_S0, 6'h3B);
    endtask : t_g3_off
    task t_rst;
        step(8'h80, SPPC_S3, 6'h1B);
        I_RESETN = 0;
        #1 chk({O_STATE, pins}, {SPPC_S0, 6'h3F});
        @(posedge I_CLOCK) #1 I_RESETN = 1;
        step(8'h00, SPPC_S0, 6'h3B);
    endtask : t_rst
    initial begin
        #29 I_RESETN = 1;
        t_s3;
        t_ovr;
        t_g3;
        t_g3_off;
        t_rst;
        results;
    end
endmodule : tb
